// ===== tb_crosspoint_switch_control.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

module tb_crosspoint_switch_control;
  timeunit 1ns;
  timeprecision 1ps;
  import xps_pkg::*;

  logic        i_clock = 1'b0;
  // Driven at time zero so the asynchronous resets see a real falling edge
  logic        i_reset_n;
  logic [2:0]  sel = 3'h5;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         scl, sda_low, sda_oe, sda_out, sda;
  logic        awready, wready, bvalid, arready, rvalid, ack;
  logic [1:0]  bresp, rresp, rs;
  xps_matrix_t sw, exp_sw = '0, inp = '0, m;
  int          n_errors = 0, comparisons = 0, cycles = 0;

  // Pull-up wins unless someone pulls low
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  always #50 i_clock = ~i_clock;

  // Hang guard, well above the run's length
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  xps_ctrl uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_select_bit0(sel[0]),
    .i_addr_select_bit1(sel[1]), .i_addr_select_bit2(sel[2]), .o_switch_closed(sw),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  xps_i2c_master u_master (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, n_errors);
  endtask

  // Each channel released at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rd;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Close bit, row, column, junk in the ignored bits, load bit
  function automatic xps_word_t wd(logic c, logic [3:0] row, logic [2:0] col, logic ld);
    return {c, row, col, 7'h2A, ld};
  endfunction

  // Model: input image takes in-range words, load copies it out
  task automatic link(input xps_word_t w);
    u_master.write_word({4'hE, sel}, w, ack);
    `CHK(ack, 1'b1)
    if (w[14:11] < 4'h8) inp[{w[13:11], w[10:8]}] = w[15];
    if (w[0]) exp_sw = inp;
    repeat (8) @(posedge i_clock);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, wdata, rs);
    `CHK(wdata, e)
  endtask

  initial
  begin
    i_reset_n <= 1'b0;
    repeat (16) @(posedge i_clock);
    `CHK(sw, exp_sw)
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    `CHK(sw, exp_sw)
    rd_chk(XPS_OFS_STATE_HI, 32'h0);
    rd_chk(XPS_OFS_INPUT_LO, 32'h0);
    done("power_up");
    link(wd(1, 4'h2, 3'h5, 1));
    `CHK(sw, exp_sw)
    u_master.q = 1250;
    link(wd(1, 4'h2, 3'h6, 1));
    u_master.q = 625;
    `CHK(sw, exp_sw)
    done("transparent");
    link(wd(1, 4'h0, 3'h0, 0));
    link(wd(1, 4'h7, 3'h7, 0));
    `CHK(sw, 64'h0000_0000_0060_0000)
    rd_chk(XPS_OFS_INPUT_LO, inp[31:0]);
    rd_chk(XPS_OFS_INPUT_HI, inp[63:32]);
    link(wd(1, 4'h0, 3'h7, 1));
    `CHK(sw, exp_sw)
    done("latched");
    link(wd(0, 4'h2, 3'h5, 1));
    `CHK(sw, exp_sw)
    u_master.write_word({4'hE, sel}, wd(1, 4'h9, 3'h0, 1), ack);
    repeat (8) @(posedge i_clock);
    `CHK(sw, exp_sw)
    done("fields");
    u_master.read_rows({4'hE, sel}, ack, m);
    `CHK(ack, 1'b1)
    `CHK(m, exp_sw)
    axi_wr(XPS_OFS_CTRL, 32'h2, rs);
    u_master.read_rows({4'hE, sel}, ack, m);
    `CHK(ack, 1'b0)
    axi_wr(XPS_OFS_CTRL, 32'h0, rs);
    done("readback");
    for (int s = 0; s < 8; s++)
    begin
      sel <= 3'(s);
      repeat (6) @(posedge i_clock);
      link(wd(1, 4'(s), 3'(s), 1));
      u_master.write_word((s % 2) ? {4'hE, 3'(s ^ 1)} : {4'hF, 3'(s)}, wd(1, 4'(s), 3'h0, 1), ack);
      `CHK(ack, 1'b0)
    end
    `CHK(sw, exp_sw)
    done("address");
    axi_rd(XPS_OFS_STATUS, wdata, rs);
    `CHK(wdata[18:16], sel)
    `CHK(wdata[15:8], 8'h0F)
    `CHK(wdata[1:0], 2'h0)
    rd_chk(XPS_OFS_STATE_HI, exp_sw[63:32]);
    axi_wr(8'h40, 32'h1, rs);
    `CHK(rs, XPS_RESP_SLVERR)
    rd_chk(8'h40, 32'h0);
    `CHK(rs, XPS_RESP_SLVERR)
    axi_wr(XPS_OFS_STATUS, 32'h0, rs);
    `CHK(rs, XPS_RESP_OKAY)
    axi_wr(XPS_OFS_CTRL, 32'h3, rs);
    `CHK(sw, 64'h0)
    rd_chk(XPS_OFS_CTRL, 32'h2);
    rd_chk(XPS_OFS_INPUT_LO, 32'h0);
    rd_chk(XPS_OFS_INPUT_HI, 32'h0);
    axi_wr(XPS_OFS_CTRL, 32'h0, rs);
    exp_sw = '0;
    inp = '0;
    done("register_bus");
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    `CHK(sw, 64'h0)
    u_master.write_word({4'hE, sel}, wd(1, 4'h3, 3'h3, 1), ack);
    repeat (8) @(posedge i_clock);
    `CHK(sw, 64'h0)
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    `CHK(sw, 64'h0)
    rd_chk(XPS_OFS_INPUT_HI, 32'h0);
    inp = '0;
    link(wd(1, 4'h1, 3'h1, 1));
    `CHK(sw, 64'h200)
    done("reset");
    summarize();
  end
endmodule

// ===== xps_ctrl.sv
// Operation
// - Sixty-four independent switches join any of eight rows to any of eight columns at once.
// - While reset is low every switch is open and the switch-state registers hold zero.
// - After power-up all switches are open and all registers zero until a valid write lands.
// - A word with the load bit at one applies the new switch positions once fully received.
// - A word with the load bit at zero only updates the input registers, not the switches.
// - Words sent with load zero then a final word with load one take effect together.
// - Switch status can be read back over the link, but not in high-speed mode.
// - Three address-select inputs form bits two to zero of the slave address.
// - The four upper slave address bits are fixed at 1110.
// - Word bit 15 closes or opens, bits 14-11 pick the row, 10-8 the column, bit 0 is load.
//
// Implementation choices: the AXI4-Lite register port and the address map.
module xps_ctrl
(
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_reset_n,
  // Link clock and data pin
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_sda_out,
  output logic                             o_sda_oe,
  // Address select straps
  input  wire logic                        i_addr_select_bit0,
  input  wire logic                        i_addr_select_bit1,
  input  wire logic                        i_addr_select_bit2,
  // Switch drivers, index row*8+column
  output xps_pkg::xps_matrix_t             o_switch_closed,
  // AXI4-Lite write
  input  wire logic [xps_pkg::XPS_AW-1:0]  i_s_axi_awaddr,
  input  wire logic                        i_s_axi_awvalid,
  output logic                             o_s_axi_awready,
  input  wire logic [31:0]                 i_s_axi_wdata,
  input  wire logic [3:0]                  i_s_axi_wstrb,
  input  wire logic                        i_s_axi_wvalid,
  output logic                             o_s_axi_wready,
  output logic [1:0]                       o_s_axi_bresp,
  output logic                             o_s_axi_bvalid,
  input  wire logic                        i_s_axi_bready,
  // AXI4-Lite read
  input  wire logic [xps_pkg::XPS_AW-1:0]  i_s_axi_araddr,
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  output logic [31:0]                      o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready
);
  import xps_pkg::*;

  xps_link_if lk ();

  xps_link u_link
  (
    .i_reset_n (i_reset_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .lk        (lk.link)
  );

  logic [XPS_PIN_W-1:0] pin_s1;
  logic [XPS_PIN_W-1:0] pin_s2;
  logic [XPS_PIN_W-1:0] pin_s3;
  logic [XPS_PIN_W-1:0] pin_st;
  logic                 frame_on;
  logic                 link_run;
  logic                 tg_s1;
  logic                 tg_s2;
  logic                 tg_s3;
  xps_matrix_t          input_reg;
  xps_matrix_t          switch_state;
  xps_matrix_t          snapshot;
  logic                 hs_mode;
  logic [2:0]           snap_sel;
  logic                 snap_hs;
  logic [7:0]           word_cnt;
  logic                 aw_got;
  logic                 w_got;
  logic [XPS_AW-1:0]    aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 sda_out;

  // Straps and link pins, three flops; a bit moves once stages two and three agree
  wire [XPS_PIN_W-1:0] pin_raw = {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0, i_sda, i_scl};
  wire [XPS_PIN_W-1:0] next_pin_st = (pin_s2 & pin_s3) | (pin_st & (pin_s2 ^ pin_s3));

  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
      pin_st <= '1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_st <= next_pin_st;
    end

  // Start and stop seen on the filtered pins
  wire scl_hi    = pin_st[XPS_PIN_SCL] & next_pin_st[XPS_PIN_SCL];
  wire start_det = scl_hi & pin_st[XPS_PIN_SDA] & ~next_pin_st[XPS_PIN_SDA];
  wire stop_det  = scl_hi & ~pin_st[XPS_PIN_SDA] & next_pin_st[XPS_PIN_SDA];

  // Link logic is held cleared between frames; released while SCL is low
  // after a start so the release never races a link clock edge
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      frame_on <= 1'b0;
      link_run <= 1'b0;
    end
    else
    begin
      frame_on <= start_det | (frame_on & ~stop_det);
      link_run <= ~(start_det | stop_det) & (link_run | (frame_on & ~pin_st[XPS_PIN_SCL]));
    end

  // Readback image, strap and mode copy only refresh outside a frame
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      snapshot <= '0;
      snap_sel <= 3'h0;
      snap_hs  <= 1'b0;
    end
    else if (!link_run)
    begin
      snapshot <= switch_state;
      snap_sel <= pin_st[XPS_PIN_ASEL +: XPS_SEL_W];
      snap_hs  <= hs_mode;
    end

  assign lk.link_run = link_run;
  assign lk.snapshot = snapshot;
  assign lk.addr_sel = snap_sel;
  assign lk.hs_mode  = snap_hs;

  // Word toggle crossing; edge taken from stages two and three only
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end
    else
    begin
      tg_s1 <= lk.word_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end

  // Word fields; the link word is stable for a full byte time after the toggle
  wire                 word_evt = tg_s2 ^ tg_s3;
  wire                 w_close  = lk.word[XPS_CLOSE_BIT];
  wire                 w_load   = lk.word[XPS_LOAD_BIT];
  wire                 row_ok   = ~lk.word[XPS_ROW_MSB];
  wire [XPS_IDX_W-1:0] sw_idx   = {lk.word[XPS_ROW_LSB +: XPS_SEL_W], lk.word[XPS_COL_LSB +: XPS_SEL_W]};
  wire                 word_hit = word_evt & row_ok;

  // Register bus decode
  wire wr_fire  = aw_got & w_got;
  wire rd_take  = i_s_axi_arvalid & o_s_axi_arready;
  wire wr_ctrl  = wr_fire & (aw_addr == XPS_OFS_CTRL) & w_strb[0];
  wire sw_clear = wr_ctrl & w_data[XPS_CTRL_CLEAR_BIT];

  // Input registers: a word lands on top of a same-cycle software clear
  xps_matrix_t next_input;
  for (genvar gi = 0; gi < XPS_NSW; gi++)
  begin : g_sw
    assign next_input[gi] = (word_hit && sw_idx == XPS_IDX_W'(gi)) ? w_close
                          : (sw_clear ? 1'b0 : input_reg[gi]);
  end

  wire          apply        = word_evt & w_load;
  xps_matrix_t  next_state;
  assign next_state = apply ? next_input : (sw_clear ? '0 : switch_state);

  // Double buffer; reset opens every switch and zeroes both stages
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      input_reg    <= '0;
      switch_state <= '0;
      word_cnt     <= 8'h00;
    end
    else
    begin
      input_reg    <= next_input;
      switch_state <= next_state;
      word_cnt     <= word_evt ? word_cnt + 8'h01 : word_cnt;
    end

  assign o_switch_closed = switch_state;

  // Control register; the mode bit blocks readback
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
      hs_mode <= 1'b0;
    else if (wr_ctrl)
      hs_mode <= w_data[XPS_CTRL_HS_BIT];

  // Write channel: address and data taken in either order
  wire next_aw_got = aw_got ? ~wr_fire : (i_s_axi_awvalid & o_s_axi_awready);
  wire next_w_got  = w_got ? ~wr_fire : (i_s_axi_wvalid & o_s_axi_wready);
  wire next_bvalid = wr_fire | (o_s_axi_bvalid & ~i_s_axi_bready);
  wire wr_mapped   = (aw_addr == XPS_OFS_CTRL) || (aw_addr == XPS_OFS_STATUS)
                  || (aw_addr == XPS_OFS_STATE_LO) || (aw_addr == XPS_OFS_STATE_HI)
                  || (aw_addr == XPS_OFS_INPUT_LO) || (aw_addr == XPS_OFS_INPUT_HI);

  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= XPS_RESP_OKAY;
    end
    else
    begin
      aw_got          <= next_aw_got;
      w_got           <= next_w_got;
      o_s_axi_awready <= ~next_aw_got & ~next_bvalid;
      o_s_axi_wready  <= ~next_w_got & ~next_bvalid;
      o_s_axi_bvalid  <= next_bvalid;
      o_s_axi_bresp   <= wr_fire ? (wr_mapped ? XPS_RESP_OKAY : XPS_RESP_SLVERR) : o_s_axi_bresp;
    end

  // Write payload held until both halves are in
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      aw_addr <= (i_s_axi_awvalid & o_s_axi_awready) ? i_s_axi_awaddr : aw_addr;
      w_data  <= (i_s_axi_wvalid & o_s_axi_wready) ? i_s_axi_wdata : w_data;
      w_strb  <= (i_s_axi_wvalid & o_s_axi_wready) ? i_s_axi_wstrb : w_strb;
    end

  // Read decode, one word per register, unused bits zero
  wire [31:0] reg_ctrl   = {30'h0, hs_mode, 1'b0};
  wire [31:0] reg_status = {13'h0, pin_st[XPS_PIN_ASEL +: XPS_SEL_W], word_cnt, 6'h0, link_run, frame_on};
  wire is_ctrl   = (i_s_axi_araddr == XPS_OFS_CTRL);
  wire is_status = (i_s_axi_araddr == XPS_OFS_STATUS);
  wire is_st_lo  = (i_s_axi_araddr == XPS_OFS_STATE_LO);
  wire is_st_hi  = (i_s_axi_araddr == XPS_OFS_STATE_HI);
  wire is_in_lo  = (i_s_axi_araddr == XPS_OFS_INPUT_LO);
  wire is_in_hi  = (i_s_axi_araddr == XPS_OFS_INPUT_HI);
  wire rd_mapped = is_ctrl | is_status | is_st_lo | is_st_hi | is_in_lo | is_in_hi;
  wire [31:0] rd_word = is_ctrl   ? reg_ctrl
                      : is_status ? reg_status
                      : is_st_lo  ? switch_state[31:0]
                      : is_st_hi  ? switch_state[63:32]
                      : is_in_lo  ? input_reg[31:0]
                      : is_in_hi  ? input_reg[63:32]
                      : 32'h0000_0000;
  wire next_rvalid = rd_take | (o_s_axi_rvalid & ~i_s_axi_rready);

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= XPS_RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= ~next_rvalid;
      o_s_axi_rvalid  <= next_rvalid;
      o_s_axi_rdata   <= rd_take ? rd_word : o_s_axi_rdata;
      o_s_axi_rresp   <= rd_take ? (rd_mapped ? XPS_RESP_OKAY : XPS_RESP_SLVERR) : o_s_axi_rresp;
    end

  // Pin outputs; the data pin is open drain so its level is always low
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;

  assign o_sda_out = sda_out;
  assign o_sda_oe  = lk.sda_oe;

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_load_word;
    word_evt && w_load;
  endsequence

  sequence s_both_in;
    aw_got && w_got;
  endsequence

  AST_RESET_OPEN: assert property ($rose(i_reset_n) |-> (switch_state == '0) && (input_reg == '0))
    else $error("switches not open after reset");
  AST_APPLY_LOAD: assert property (s_load_word |=> (o_switch_closed == input_reg))
    else $error("load word did not apply input registers");
  AST_LATCH_HOLD: assert property (word_evt && !w_load && !sw_clear |=> $stable(o_switch_closed))
    else $error("latched word changed switches");
  AST_INPUT_SET: assert property (word_hit |=> input_reg[$past(sw_idx)] == $past(w_close))
    else $error("word did not set addressed input bit");
  AST_ROW_IGNORED: assert property (word_evt && !row_ok && !sw_clear |=> $stable(input_reg))
    else $error("out of range row changed inputs");
  AST_CLEAR_ALL: assert property (sw_clear && !word_evt |=> (switch_state == '0) && (input_reg == '0))
    else $error("software clear left switches set");
  AST_WRITE_RESP: assert property (s_both_in |=> o_s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");
  AST_SNAP_FROZEN: assert property (link_run |=> $stable(snapshot))
    else $error("readback image moved during frame");
  AST_START_HOLDS: assert property (start_det |=> !link_run ##1 !link_run)
    else $error("link not cleared on start");
endmodule

// ===== xps_i2c_master.sv
module xps_i2c_master
(
  // Serial pins; SDA open drain, SCL driven high and low
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  import xps_pkg::*;

  // Quarter SCL period; raise it for a slow master
  int q = 625;

  // Bus idles released, SCL still between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data changes only while SCL is low
  task automatic put_bit(input logic b);
    #q;
    o_sda_low = ~b;
    #q;
    o_scl = 1'b1;
    #(2*q);
    o_scl = 1'b0;
  endtask

  // Sample mid-high, clear of the slave's change at SCL fall
  task automatic get_bit(output logic b);
    o_sda_low = 1'b0;
    #(2*q);
    o_scl = 1'b1;
    #q;
    b = i_sda;
    #q;
    o_scl = 1'b0;
  endtask

  task automatic start_cond;
    o_sda_low = 1'b0;
    o_scl = 1'b1;
    #(2*q);
    o_sda_low = 1'b1;
    #(2*q);
    o_scl = 1'b0;
  endtask

  task automatic stop_cond;
    #q;
    o_sda_low = 1'b1;
    #q;
    o_scl = 1'b1;
    #(2*q);
    o_sda_low = 1'b0;
    #(2*q);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(a);
    ack = ~a;
  endtask

  // One word per frame; reset is never touched by this model
  task automatic write_word(input logic [6:0] addr, input xps_word_t w, output logic ack);
    logic a0, a1, a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(w[15:8], a1);
    send_byte(w[7:0], a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask

  // Rows in order, NACK on the last one ends the slave's driving
  task automatic read_rows(input logic [6:0] addr, output logic ack, output logic [63:0] m);
    logic [7:0] b;
    m = '0;
    start_cond();
    send_byte({addr, 1'b1}, ack);
    for (int r = 0; r < 8 && ack; r++)
    begin
      for (int i = 7; i >= 0; i--)
        get_bit(b[i]);
      put_bit(r == 7);
      m[r*8 +: 8] = b;
    end
    stop_cond();
  endtask
endmodule

// ===== xps_link.sv
module xps_link
(
  // Resets and link clock
  input wire logic i_reset_n,
  input wire logic i_scl,
  // Serial data pin
  input wire logic i_sda,
  // System side
  xps_link_if.link lk
);
  import xps_pkg::*;

  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] word_hi;
  logic       addr_ok;
  logic       rd;
  logic       ack_due;
  logic       rx_nack;
  logic [2:0] rb_row;

  // Byte decode
  wire [7:0] full_byte   = {shreg[6:0], i_sda};
  wire       end_of_byte = (bit_cnt == XPS_BIT_LAST);
  wire       in_ack      = (bit_cnt == XPS_BIT_ACK);
  wire       addr_match  = (full_byte[7:1] == {XPS_ADDR_HI, lk.addr_sel});
  wire       hs_read     = full_byte[0] & lk.hs_mode;
  wire       word_done   = end_of_byte & addr_ok & ~rd & (byte_idx == 2'h2);
  wire [7:0] rb_byte     = lk.snapshot[rb_row*XPS_COLS +: XPS_COLS];
  wire [3:0] rb_pos      = XPS_BIT_LAST - bit_cnt;
  wire       rb_bit      = rb_byte[rb_pos[2:0]];
  wire       read_drive  = addr_ok & rd & ~rx_nack & ~rb_bit;

  // Bit counter; frame signal clears it so a stopped clock never strands it
  always_ff @(posedge i_scl or negedge lk.link_run)
    if (!lk.link_run)
    begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      rx_nack <= 1'b0;
    end
    else if (in_ack)
    begin
      bit_cnt <= 4'h0;
      rx_nack <= rx_nack | (rd & i_sda);
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg   <= full_byte;
    end

  // Byte handling: address, word halves, readback rows
  always_ff @(posedge i_scl or negedge lk.link_run)
    if (!lk.link_run)
    begin
      byte_idx <= 2'h0;
      word_hi  <= 8'h00;
      addr_ok  <= 1'b0;
      rd       <= 1'b0;
      ack_due  <= 1'b0;
      rb_row   <= 3'h0;
    end
    else if (end_of_byte)
    begin
      if (byte_idx == 2'h0)
      begin
        addr_ok  <= addr_match & ~hs_read;
        ack_due  <= addr_match & ~hs_read;
        rd       <= full_byte[0];
        byte_idx <= 2'h1;
      end
      else if (rd)
      begin
        rb_row  <= rb_row + 3'h1;
        ack_due <= 1'b0;
      end
      else
      begin
        word_hi  <= (byte_idx == 2'h1) ? full_byte : word_hi;
        byte_idx <= (byte_idx == 2'h1) ? 2'h2 : 2'h1;
        ack_due  <= addr_ok;
      end
    end

  // Finished word survives the frame; only device reset clears it
  always_ff @(posedge i_scl or negedge i_reset_n)
    if (!i_reset_n)
    begin
      lk.word     <= '0;
      lk.word_tgl <= 1'b0;
    end
    else if (word_done)
    begin
      lk.word     <= {word_hi, full_byte};
      lk.word_tgl <= ~lk.word_tgl;
    end

  // Drive on falling edge so SDA is stable across SCL high
  always_ff @(negedge i_scl or negedge lk.link_run)
    if (!lk.link_run)
      lk.sda_oe <= 1'b0;
    else
      lk.sda_oe <= in_ack ? ack_due : read_drive;
endmodule

// ===== xps_link_if.sv
interface xps_link_if;
  import xps_pkg::*;
  logic        link_run;
  logic [2:0]  addr_sel;
  logic        hs_mode;
  xps_matrix_t snapshot;
  logic        word_tgl;
  xps_word_t   word;
  logic        sda_oe;

  modport sys
  (
    output link_run, addr_sel, hs_mode, snapshot,
    input  word_tgl, word, sda_oe
  );
  modport link
  (
    input  link_run, addr_sel, hs_mode, snapshot,
    output word_tgl, word, sda_oe
  );
endinterface

// ===== xps_pkg.sv
package xps_pkg;
  // Matrix geometry
  localparam int XPS_ROWS  = 8;
  localparam int XPS_COLS  = 8;
  localparam int XPS_NSW   = XPS_ROWS * XPS_COLS;
  localparam int XPS_IDX_W = 6;
  localparam int XPS_SEL_W = 3;

  typedef logic [15:0]        xps_word_t;
  typedef logic [XPS_NSW-1:0] xps_matrix_t;

  // Upper four bits of the 7-bit slave address
  localparam logic [3:0] XPS_ADDR_HI = 4'hE;

  // Switch word fields
  localparam int XPS_CLOSE_BIT = 15;
  localparam int XPS_ROW_MSB   = 14;
  localparam int XPS_ROW_LSB   = 11;
  localparam int XPS_COL_LSB   = 8;
  localparam int XPS_LOAD_BIT  = 0;

  // Bit counter within a link byte
  localparam logic [3:0] XPS_BIT_LAST = 4'h7;
  localparam logic [3:0] XPS_BIT_ACK  = 4'h8;

  // Pin vector layout for the system-side synchroniser
  localparam int XPS_PIN_W    = 5;
  localparam int XPS_PIN_SCL  = 0;
  localparam int XPS_PIN_SDA  = 1;
  localparam int XPS_PIN_ASEL = 2;

  // Register bus
  localparam int               XPS_AW         = 8;
  localparam logic [XPS_AW-1:0] XPS_OFS_CTRL     = 8'h00;
  localparam logic [XPS_AW-1:0] XPS_OFS_STATUS   = 8'h04;
  localparam logic [XPS_AW-1:0] XPS_OFS_STATE_LO = 8'h08;
  localparam logic [XPS_AW-1:0] XPS_OFS_STATE_HI = 8'h0C;
  localparam logic [XPS_AW-1:0] XPS_OFS_INPUT_LO = 8'h10;
  localparam logic [XPS_AW-1:0] XPS_OFS_INPUT_HI = 8'h14;
  localparam int XPS_CTRL_CLEAR_BIT = 0;
  localparam int XPS_CTRL_HS_BIT    = 1;
  localparam logic [1:0] XPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] XPS_RESP_SLVERR = 2'h2;
endpackage
